// [logic/tci_channel_ctrl.sv]
// Channel input conditioning, enables and polarity with register slave
module tci_channel_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel pins and compare references
   input wire logic [3:0] ch_raw_input,
   input wire logic [3:0] ch_ref,
   input wire logic [1:0] internal_trigger_select,
   output logic [3:0] ch_main_output,
   output logic [3:0] ch_main_oe,
   output logic [2:0] ch_comp_output,
   output logic [2:0] ch_comp_oe,
   // Events
   output logic [1:0] ch_trigger,
   output logic [1:0] capture_pulse,
   output logic irq
);

   typedef struct packed {
      tci_pkg::tci_input_cfg_t incfg;
      logic [15:0] cep;
      logic [1:0] protection_level;
      logic [15:0] mode01;
      logic [1:0] istat;
      logic [1:0] ien;
      logic aw_v;
      logic [7:0] aw_a;
      logic w_v;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bv;
      logic [1:0] bresp;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rresp;
      logic [1:0] sel_prev;
      logic [1:0][2:0] pcnt;
      logic [1:0] cap;
      logic [1:0] trig;
      logic [3:0] mout;
      logic [3:0] moe;
      logic [2:0] cout;
      logic [2:0] coe;
   } tci_state_t;

   tci_state_t s_q;
   tci_state_t s_d;
   logic [3:0][1:0] mode_c;
   logic [1:0] filt_c;
   logic [1:0] sel_c;
   logic [1:0] edge_c;
   logic wr_go;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic [15:0] wmask;
   logic [15:0] wmerge;
   logic [15:0] cep_new;
   logic [15:0] cfg_new;
   logic [15:0] m01_new;
   logic [1:0] md;
   logic [1:0] dv;
   logic [2:0] lim;
   logic en;
   logic pol;

   ////////////////////////////////////////////////////////////////////////////////
   // Input filters for channels 2 and 3
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_flt
         tci_filt_if fif ();
         assign fif.sel = (k == 0) ? s_q.incfg.ch2_input_filter_sel
                                   : s_q.incfg.ch3_input_filter_sel;
         assign fif.raw = ch_raw_input[k + 2];
         assign filt_c[k] = fif.filt;
         tci_input_filter u_flt (
            .clk_sys (clk_sys),
            .resetn (resetn),
            .fi (fif.flt)
         );
      end
   endgenerate

   assign mode_c = {s_q.incfg.ch3_mode_sel, s_q.incfg.ch2_mode_sel,
                    s_q.mode01[tci_pkg::MODE1_LSB +: 2], s_q.mode01[1:0]};

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      sel_c = '0;
      edge_c = '0;
      md = '0;
      dv = '0;
      lim = '0;
      en = 1'b0;
      pol = 1'b0;
      waddr = {s_q.aw_a[7:2], 2'b00};
      raddr = {s_axi_araddr[7:2], 2'b00};
      wr_go = s_q.aw_v && s_q.w_v && !s_q.bv;
      wmask = {{8{s_q.w_s[1]}}, {8{s_q.w_s[0]}}};
      wmerge = s_q.w_d[15:0] & wmask;
      cep_new = ((s_q.cep & ~wmask) | wmerge) & tci_pkg::CEP_USED_MASK;
      cfg_new = (s_q.incfg & ~wmask) | wmerge;
      m01_new = ((s_q.mode01 & ~wmask) | wmerge) & tci_pkg::MODE01_MASK;

      // Address and data may arrive in either order
      if (s_axi_awvalid && !s_q.aw_v) begin
         s_d.aw_v = 1'b1;
         s_d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_v) begin
         s_d.w_v = 1'b1;
         s_d.w_d = s_axi_wdata;
         s_d.w_s = s_axi_wstrb;
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////////
      // Register writes
      if (wr_go) begin
         s_d.aw_v = 1'b0;
         s_d.w_v = 1'b0;
         s_d.bv = 1'b1;
         s_d.bresp = tci_pkg::RESP_OKAY;
         if (waddr == tci_pkg::ADDR_INPUT_CFG) begin
            if (s_q.cep[2 * tci_pkg::CEP_GRP + tci_pkg::CEP_EN]) begin
               cfg_new[1:0] = s_q.incfg.ch2_mode_sel;
            end
            if (s_q.cep[3 * tci_pkg::CEP_GRP + tci_pkg::CEP_EN]) begin
               cfg_new[9:8] = s_q.incfg.ch3_mode_sel;
            end
            s_d.incfg = tci_pkg::tci_input_cfg_t'(cfg_new);
         end else if (waddr == tci_pkg::ADDR_CEP) begin
            for (int i = 0; i < 4; i++) begin
               if (s_q.protection_level[1]) begin
                  cep_new[i * tci_pkg::CEP_GRP + tci_pkg::CEP_P] =
                     s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_P];
               end
               if (i < 3 && s_q.protection_level[1] && mode_c[i] == tci_pkg::MODE_OUT) begin
                  cep_new[i * tci_pkg::CEP_GRP + tci_pkg::CEP_NP] =
                     s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_NP];
               end
            end
            s_d.cep = cep_new;
         end else if (waddr == tci_pkg::ADDR_PROTECTION_LEVEL) begin
            if (s_q.w_s[1]) begin
               s_d.protection_level = s_q.w_d[tci_pkg::PROTECTION_LEVEL_LSB +: 2];
            end
         end else if (waddr == tci_pkg::ADDR_MODE01) begin
            // Same lock for channels 0 and 1
            if (s_q.cep[tci_pkg::CEP_EN]) begin
               m01_new[1:0] = s_q.mode01[1:0];
            end
            if (s_q.cep[tci_pkg::CEP_GRP + tci_pkg::CEP_EN]) begin
               m01_new[tci_pkg::MODE1_LSB +: 2] = s_q.mode01[tci_pkg::MODE1_LSB +: 2];
            end
            s_d.mode01 = m01_new;
         end else if (waddr == tci_pkg::ADDR_ICLR) begin
            if (s_q.w_s[0]) begin
               s_d.istat = s_q.istat & ~s_q.w_d[1:0];
            end
         end else if (waddr == tci_pkg::ADDR_IEN) begin
            if (s_q.w_s[0]) begin
               s_d.ien = s_q.w_d[1:0];
            end
         end else if (waddr != tci_pkg::ADDR_ISTAT) begin
            s_d.bresp = tci_pkg::RESP_SLVERR;
         end
      end

      ////////////////////////////////////////////////////////////////////////////
      // Register reads
      if (s_axi_arvalid && !s_q.rv) begin
         s_d.rv = 1'b1;
         s_d.rresp = tci_pkg::RESP_OKAY;
         s_d.rd = 32'h0000_0000;
         if (raddr == tci_pkg::ADDR_INPUT_CFG) begin
            s_d.rd = {16'h0000, s_q.incfg};
         end else if (raddr == tci_pkg::ADDR_CEP) begin
            s_d.rd = {16'h0000, s_q.cep};
         end else if (raddr == tci_pkg::ADDR_PROTECTION_LEVEL) begin
            s_d.rd = {22'h000000, s_q.protection_level, 8'h00};
         end else if (raddr == tci_pkg::ADDR_MODE01) begin
            s_d.rd = {16'h0000, s_q.mode01};
         end else if (raddr == tci_pkg::ADDR_ISTAT) begin
            s_d.rd = {30'h00000000, s_q.istat};
         end else if (raddr == tci_pkg::ADDR_IEN) begin
            s_d.rd = {30'h00000000, s_q.ien};
         end else if (raddr != tci_pkg::ADDR_ICLR) begin
            s_d.rresp = tci_pkg::RESP_SLVERR;
         end
      end

      ////////////////////////////////////////////////////////////////////////////
      // Capture path, index 0 is channel 2 and index 1 channel 3
      s_d.cap = 2'h0;
      for (int c = 0; c < 2; c++) begin
         md = mode_c[c + 2];
         dv = (c == 0) ? s_q.incfg.ch2_capture_divider : s_q.incfg.ch3_capture_divider;
         en = s_q.cep[(c + 2) * tci_pkg::CEP_GRP + tci_pkg::CEP_EN];
         pol = s_q.cep[(c + 2) * tci_pkg::CEP_GRP + tci_pkg::CEP_P];
         if (md == tci_pkg::MODE_OWN) begin
            sel_c[c] = filt_c[c];
         end else if (md == tci_pkg::MODE_CROSS) begin
            sel_c[c] = filt_c[1 - c];
         end else begin
            sel_c[c] = internal_trigger_select[c];
         end
         s_d.sel_prev[c] = sel_c[c] ^ pol;
         s_d.trig[c] = sel_c[c] ^ pol;
         edge_c[c] = (sel_c[c] ^ pol) && !s_q.sel_prev[c];
         lim = 3'((4'h1 << dv) - 4'h1);
         if (!en) begin
            s_d.pcnt[c] = 3'h0;
         end else if (edge_c[c] && md != tci_pkg::MODE_OUT) begin
            if (s_q.pcnt[c] >= lim) begin
               s_d.pcnt[c] = 3'h0;
               s_d.cap[c] = 1'b1;
            end else begin
               s_d.pcnt[c] = s_q.pcnt[c] + 3'h1;
            end
         end
      end

      ////////////////////////////////////////////////////////////////////////////
      // Output stage, dead time lives elsewhere
      for (int i = 0; i < 4; i++) begin
         s_d.moe[i] = s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_EN]
                      && mode_c[i] == tci_pkg::MODE_OUT;
         s_d.mout[i] = s_d.moe[i]
                       && (ch_ref[i] ^ s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_P]);
      end
      for (int i = 0; i < 3; i++) begin
         s_d.coe[i] = s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_NEN]
                      && mode_c[i] == tci_pkg::MODE_OUT;
         s_d.cout[i] = s_d.coe[i]
                       && (!ch_ref[i] ^ s_q.cep[i * tci_pkg::CEP_GRP + tci_pkg::CEP_NP]);
      end

      // Sticky capture flags; a set in the clear cycle wins
      s_d.istat = s_d.istat | s_d.cap;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.incfg <= tci_pkg::tci_input_cfg_t'(tci_pkg::RST_INPUT_CFG);
         s_q.cep <= tci_pkg::RST_CEP;
         s_q.protection_level <= tci_pkg::RST_PROTECTION_LEVEL;
         s_q.mode01 <= tci_pkg::RST_MODE01;
         s_q.istat <= tci_pkg::RST_IRQ;
         s_q.ien <= tci_pkg::RST_IRQ;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready = !s_q.aw_v;
   assign s_axi_wready = !s_q.w_v;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rv;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rd;
   assign s_axi_rresp = s_q.rresp;
   assign ch_main_output = s_q.mout;
   assign ch_main_oe = s_q.moe;
   assign ch_comp_output = s_q.cout;
   assign ch_comp_oe = s_q.coe;
   assign ch_trigger = s_q.trig;
   assign capture_pulse = s_q.cap;
   assign irq = |(s_q.istat & s_q.ien);

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_div_clear;
      !s_q.cep[8] |=> s_q.pcnt[0] == 3'h0;
   endproperty
   a_div_clear: assert property (p_div_clear) else $error("edge counter not cleared");

   property p_every_edge;
      s_q.cep[8] && mode_c[2] != 2'h0 && s_q.incfg.ch2_capture_divider == 2'h0
         && edge_c[0] |=> capture_pulse[0];
   endproperty
   a_every_edge: assert property (p_every_edge) else $error("capture missed");

   property p_cap_gate;
      capture_pulse[1] |-> $past(s_q.cep[12]) && $past(mode_c[3]) != 2'h0;
   endproperty
   a_cap_gate: assert property (p_cap_gate) else $error("capture while disabled");

   property p_main_pol;
      1'b1 |=> ch_main_oe[1] == $past(s_q.cep[4] && mode_c[1] == 2'h0)
         && ch_main_output[1] == (ch_main_oe[1]
         && ($past(ch_ref[1]) ^ $past(s_q.cep[5])));
   endproperty
   a_main_pol: assert property (p_main_pol) else $error("main output level wrong");

   property p_comp_out;
      1'b1 |=> ch_comp_oe[2] == $past(s_q.cep[10] && mode_c[2] == 2'h0)
         && ch_comp_output[2] == (ch_comp_oe[2] && ($past(!ch_ref[2]) ^ $past(s_q.cep[11])));
   endproperty
   a_comp_out: assert property (p_comp_out) else $error("comp output wrong");

   property p_trig_pol;
      1'b1 |=> ch_trigger[1] == ($past(sel_c[1]) ^ $past(s_q.cep[13]));
   endproperty
   a_trig_pol: assert property (p_trig_pol) else $error("trigger polarity wrong");

   property p_pol_lock;
      wr_go && waddr == 8'h20 && s_q.protection_level[1] |=> $stable(s_q.cep[13]) && $stable(s_q.cep[1]);
   endproperty
   a_pol_lock: assert property (p_pol_lock) else $error("polarity changed under lock");

   property p_np_lock;
      wr_go && waddr == 8'h20 && s_q.protection_level[1] && mode_c[0] == 2'h0 |=> $stable(s_q.cep[3]);
   endproperty
   a_np_lock: assert property (p_np_lock) else $error("comp polarity changed");

   property p_mode_lock;
      wr_go && waddr == 8'h1C && s_q.cep[8] |=> $stable(s_q.incfg.ch2_mode_sel);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode changed while enabled");

   property p_rsvd;
      s_axi_rvalid && $rose(s_axi_rvalid) && $past(raddr) == 8'h20 |-> s_axi_rdata[31:14] == '0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

endmodule // tci_channel_ctrl

// [logic/tci_pkg.sv]
// Constants, register layouts and filter tables for the timer channel input block
package tci_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_INPUT_CFG = 8'h1C;
   localparam logic [7:0] ADDR_CEP = 8'h20;
   localparam logic [7:0] ADDR_PROTECTION_LEVEL = 8'h44;
   localparam logic [7:0] ADDR_MODE01 = 8'h48;
   localparam logic [7:0] ADDR_ISTAT = 8'h4C;
   localparam logic [7:0] ADDR_ICLR = 8'h50;
   localparam logic [7:0] ADDR_IEN = 8'h54;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [15:0] RST_INPUT_CFG = 16'h0000;
   localparam logic [15:0] RST_CEP = 16'h0000;
   localparam logic [15:0] RST_MODE01 = 16'h0000;
   localparam logic [1:0] RST_PROTECTION_LEVEL = 2'h0;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [15:0] CEP_USED_MASK = 16'h3FFF;
   localparam logic [15:0] MODE01_MASK = 16'h0303;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CEP_GRP = 4;
   localparam int CEP_EN = 0;
   localparam int CEP_P = 1;
   localparam int CEP_NEN = 2;
   localparam int CEP_NP = 3;
   localparam int PROTECTION_LEVEL_LSB = 8;
   localparam int MODE1_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode codes and bus answers
   localparam logic [1:0] MODE_OUT = 2'h0;
   localparam logic [1:0] MODE_OWN = 2'h1;
   localparam logic [1:0] MODE_CROSS = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] ch3_input_filter_sel;
      logic [1:0] ch3_capture_divider;
      logic [1:0] ch3_mode_sel;
      logic [3:0] ch2_input_filter_sel;
      logic [1:0] ch2_capture_divider;
      logic [1:0] ch2_mode_sel;
   } tci_input_cfg_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Equal samples needed per filter setting
   function automatic logic [3:0] tci_flt_need(input logic [3:0] sel);
      case (sel)
         4'h1: tci_flt_need = 4'h2;
         4'h2: tci_flt_need = 4'h4;
         4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: tci_flt_need = 4'h8;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: tci_flt_need = 4'h6;
         4'hA, 4'hD: tci_flt_need = 4'h5;
         default: tci_flt_need = 4'h0;
      endcase
   endfunction

   // Log2 of the sampling divider applied to the dead-time clock
   function automatic logic [2:0] tci_flt_shift(input logic [3:0] sel);
      case (sel)
         4'h4, 4'h5: tci_flt_shift = 3'h1;
         4'h6, 4'h7: tci_flt_shift = 3'h2;
         4'h8, 4'h9: tci_flt_shift = 3'h3;
         4'hA, 4'hB, 4'hC: tci_flt_shift = 3'h4;
         4'hD, 4'hE, 4'hF: tci_flt_shift = 3'h5;
         default: tci_flt_shift = 3'h0;
      endcase
   endfunction

endpackage

// [logic/tci_filt_if.sv]
// Link between the channel logic and one input filter
interface tci_filt_if;
   logic [3:0] sel;
   logic raw;
   logic filt;
   modport ctl (output sel, output raw, input filt);
   modport flt (input sel, input raw, output filt);
endinterface

// [logic/tci_input_filter.sv]
// Digital input filter with selectable sampling rate and sample count
module tci_input_filter (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Filter link
   tci_filt_if.flt fi
);

   typedef struct packed {
      logic [4:0] div;
      logic last;
      logic [3:0] cnt;
      logic filt;
   } tci_flt_state_t;

   tci_flt_state_t s_q;
   tci_flt_state_t s_d;
   logic [3:0] need;
   logic [4:0] mask;
   logic tick;
   logic [3:0] nc;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      // Dead-time sample clock equals the kernel clock here
      s_d.div = s_q.div + 5'h01;
      need = tci_pkg::tci_flt_need(fi.sel);
      mask = 5'((6'h01 << tci_pkg::tci_flt_shift(fi.sel)) - 6'h01);
      tick = (s_q.div & mask) == 5'h00;
      nc = s_q.cnt;
      if (fi.sel == 4'h0) begin
         s_d.filt = fi.raw;
         s_d.last = fi.raw;
         s_d.cnt = 4'h0;
      end else if (tick) begin
         if (fi.raw != s_q.last) begin
            nc = 4'h1;
         end else if (s_q.cnt < need) begin
            nc = s_q.cnt + 4'h1;
         end
         s_d.last = fi.raw;
         s_d.cnt = nc;
         if (nc >= need) begin
            s_d.filt = fi.raw;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign fi.filt = s_q.filt;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_fast_high;
      (fi.sel == 4'h1 && fi.raw) [*2];
   endsequence

   property p_bypass;
      fi.sel == 4'h0 |=> fi.filt == $past(fi.raw);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass filter lags");

   property p_fast_accept;
      s_fast_high |=> fi.filt;
   endproperty
   a_fast_accept: assert property (p_fast_accept) else $error("two samples not taken");

   property p_hold;
      !$stable(fi.filt) |-> fi.filt == $past(fi.raw);
   endproperty
   a_hold: assert property (p_hold) else $error("filter output moved alone");

endmodule // tci_input_filter

// [test/tci_pin_model.sv]
// Pin-side model that drives the raw channel inputs
module tci_pin_model (
   // Clock
   input wire logic clk_sys,
   // Requested pin levels
   input wire logic [3:0] level,
   // Pins
   output logic [3:0] ch_raw_input
);
   timeunit 1ns;
   timeprecision 1ns;
   initial ch_raw_input = 4'h0;
   // Pins move just after the edge, as a synchronous source would
   always @(posedge clk_sys) begin
      ch_raw_input <= level;
   end
endmodule // tci_pin_model

// [test/test_tci_channel_ctrl.sv]
// Register-level bench for the channel input and enable block
module test_tci_channel_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, trig, cap;
   logic [3:0] lvl = 4'h0, raw, ref_q = 4'h0, mo, moe;
   logic [1:0] itrg = 2'h0;
   logic [2:0] co, coe;
   int error_cnt = 0, tests_run = 0, n2 = 0, n3 = 0, i, c0;
   always #20 clk_sys = ~clk_sys;
   // Capture pulses last one cycle, so count them at every edge
   always @(posedge clk_sys) begin
      n2 <= n2 + int'(cap[0] === 1'b1);
      n3 <= n3 + int'(cap[1] === 1'b1);
   end
   tci_pin_model pins (.clk_sys(clk_sys), .level(lvl), .ch_raw_input(raw));
   tci_channel_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ch_raw_input(raw), .ch_ref(ref_q),
      .internal_trigger_select(itrg), .ch_main_output(mo), .ch_main_oe(moe),
      .ch_comp_output(co), .ch_comp_oe(coe), .ch_trigger(trig), .capture_pulse(cap),
      .irq(irq));
   ////////////////////////////////////////
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write (w=1) checks the response; read checks response and data d
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic ta, tw, done;
      logic [1:0] rs;
      logic [31:0] rd;
      done = 1'b0;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w;
      rready <= !w;
      for (int n = 0; n < 40 && !done; n++) begin
         @(negedge clk_sys);
         ta = (awvalid && awready) || (arvalid && arready);
         tw = wvalid && wready;
         done = w ? bvalid : rvalid;
         rs = w ? bresp : rresp;
         rd = rdata;
         @(posedge clk_sys);
         if (ta) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      // One edge between calls, so ready lines are never set twice at once
      @(posedge clk_sys);
      if (!done) begin
         error_cnt++;
         stop_test();
      end
      chk(32'(rs), 32'(er));
      if (!w) chk(rd, d);
   endtask
   task automatic pin(input int c, input int h, input int k);
      repeat (k) begin
         lvl[c] <= 1'b1;
         repeat (h) @(posedge clk_sys);
         lvl[c] <= 1'b0;
         repeat (h) @(posedge clk_sys);
      end
      repeat (12) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      bus(0, tci_pkg::ADDR_CEP, tci_pkg::RST_CEP, 2'h0);
      bus(1, tci_pkg::ADDR_CEP, 32'hFFFF, 2'h0);
      bus(0, tci_pkg::ADDR_CEP, 32'h3FFF, 2'h0);
      bus(1, tci_pkg::ADDR_INPUT_CFG, 32'h0101, 2'h0);
      bus(0, tci_pkg::ADDR_INPUT_CFG, 32'h0, 2'h0);
      ref_q <= 4'h5;
      repeat (3) @(posedge clk_sys);
      chk(32'(mo), 32'hA);
      chk(32'(moe), 32'hF);
      chk(32'(co), 32'h5);
      chk(32'(coe), 32'h7);
      for (i = 2; i < 4; i++) begin
         bus(1, tci_pkg::ADDR_PROTECTION_LEVEL, 32'(i) << 8, 2'h0);
         bus(1, tci_pkg::ADDR_CEP, 32'h0, 2'h0);
         bus(0, tci_pkg::ADDR_CEP, 32'h2AAA, 2'h0);
      end
      bus(1, tci_pkg::ADDR_PROTECTION_LEVEL, 32'h0, 2'h0);
      bus(1, tci_pkg::ADDR_CEP, 32'h0, 2'h0);
      bus(1, 8'h00, 32'h0, tci_pkg::RESP_SLVERR);
      bus(0, 8'h30, 32'h0, tci_pkg::RESP_SLVERR);
      for (i = 0; i < 4; i++) begin
         bus(1, tci_pkg::ADDR_CEP, 32'h0, 2'h0);
         bus(1, tci_pkg::ADDR_INPUT_CFG, 32'h3111 | (32'(i) << 2), 2'h0);
         bus(1, tci_pkg::ADDR_CEP, 32'h1100, 2'h0);
         c0 = n2;
         pin(2, 2, 8);
         chk(32'(n2 - c0), 32'(8 >> i));
      end
      bus(1, tci_pkg::ADDR_INPUT_CFG, 32'h3105, 2'h0);
      pin(2, 2, 1);
      bus(1, tci_pkg::ADDR_CEP, 32'h1000, 2'h0);
      bus(1, tci_pkg::ADDR_CEP, 32'h1100, 2'h0);
      c0 = n2;
      pin(2, 2, 1);
      chk(32'(n2 - c0), 32'h0);
      chk(32'(irq), 32'h0);
      bus(0, tci_pkg::ADDR_ISTAT, 32'h1, 2'h0);
      bus(1, tci_pkg::ADDR_IEN, 32'h3, 2'h0);
      chk(32'(irq), 32'h1);
      bus(1, tci_pkg::ADDR_ICLR, 32'h1, 2'h0);
      bus(0, tci_pkg::ADDR_ISTAT, 32'h0, 2'h0);
      chk(32'(irq), 32'h0);
      // Short pulses must die in the eight-sample filter
      pin(3, 5, 2);
      chk(32'(n3), 32'h0);
      pin(3, 12, 1);
      chk(32'(n3), 32'h1);
      bus(1, tci_pkg::ADDR_CEP, 32'h1300, 2'h0);
      repeat (2) @(posedge clk_sys);
      chk(32'(trig[0]), 32'h1);
      bus(1, tci_pkg::ADDR_CEP, 32'h0, 2'h0);
      bus(1, tci_pkg::ADDR_INPUT_CFG, 32'h4302, 2'h0);
      bus(1, tci_pkg::ADDR_CEP, 32'h1100, 2'h0);
      // Eight-cycle pulses give four half-rate samples, short of six
      c0 = n2;
      pin(3, 8, 2);
      chk(32'(n2 - c0), 32'h0);
      pin(3, 14, 1);
      chk(32'(n2 - c0), 32'h1);
      c0 = n3;
      itrg <= 2'h2;
      repeat (3) @(posedge clk_sys);
      chk(32'(trig[1]), 32'h1);
      itrg <= 2'h0;
      repeat (3) @(posedge clk_sys);
      chk(32'(n3 - c0), 32'h1);
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      stop_test();
   end
endmodule // test_tci_channel_ctrl
